//--- rtl/lis_sequencer.sv
// Laser enable interlock sequencer with APB status and control registers.
`timescale 1ns/1ps
`default_nettype none

module lis_sequencer #(
  parameter int unsigned DLY_CYC = lis_pkg::ENABLE_DLY_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        interlock_in,
  input  wire logic        shutter_req_in,
  input  wire logic        shutter_sw_open_in,
  input  wire logic        inhibit_req_in,
  input  wire logic        over_temp_in,
  input  wire logic        pwm_in,
  output logic             rf_power_en,
  output logic             pwm_gate,
  output logic             ready_oe_n,
  output logic             shutter_open_oe_n,
  output logic             interlock_open_oe_n,
  output logic             over_temp_oe_n,
  output logic             lase_active_oe_n
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  lis_pkg::lis_state_t       st_ff;
  lis_pkg::lis_state_t       nxt_st;
  logic                      ot_ff;
  logic                      nxt_ot;
  logic                      ctrl_ff;
  logic                      nxt_ctrl;
  logic                      rf_ff;
  logic                      nxt_rf;
  logic                      pwm_gate_ff;
  logic                      nxt_pwm_gate;
  logic                      ready_oe_n_ff;
  logic                      nxt_ready_oe_n;
  logic                      shut_oe_n_ff;
  logic                      nxt_shut_oe_n;
  logic                      ilk_oe_n_ff;
  logic                      nxt_ilk_oe_n;
  logic                      ot_oe_n_ff;
  logic                      nxt_ot_oe_n;
  logic                      lase_oe_n_ff;
  logic                      nxt_lase_oe_n;
  logic [31:0]               prdata_ff;
  logic [31:0]               nxt_prdata;
  logic                      pready_ff;
  logic                      nxt_pready;
  logic                      pslverr_ff;
  logic                      nxt_pslverr;
  logic                      shut_stat;
  logic                      ready_cond;
  logic                      allow;
  logic                      tmr_run;
  logic                      tmr_done;
  logic [lis_pkg::TMR_W-1:0] tmr_cnt;
  logic                      setup;
  logic                      wr_acc;
  logic                      lase_en;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic is_mapped(input logic [7:0] a);
    if (a == lis_pkg::OFS_CTRL) begin
      return 1'b1;
    end else if (a == lis_pkg::OFS_STATUS) begin
      return 1'b1;
    end else if (a == lis_pkg::OFS_TIMER) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction

  // ----------------------------------------------------------------
  // Enable conditions
  // ----------------------------------------------------------------
  // shutter status term
  assign shut_stat  = shutter_sw_open_in && shutter_req_in;
  // inhibit and latched fault hold ready off
  assign ready_cond = interlock_in && shutter_req_in && !inhibit_req_in && !ot_ff
                      && !ctrl_ff;
  assign allow      = interlock_in && ready_cond && shut_stat;
  assign lase_en    = (st_ff == lis_pkg::SEQ_LASE);
  assign tmr_run    = (st_ff == lis_pkg::SEQ_WAIT) && allow;

  lis_delay_timer #(
    .LIMIT (DLY_CYC)
  ) u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (tmr_run),
    .cnt     (tmr_cnt),
    .done    (tmr_done)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_ot = ot_ff || over_temp_in;
    nxt_st = st_ff;
    case (st_ff)
      lis_pkg::SEQ_OFF: begin
        // power-up and interlock return start the delay
        if (nxt_ot) begin
          nxt_st = lis_pkg::SEQ_OT;
        end else if (allow) begin
          nxt_st = lis_pkg::SEQ_WAIT;
        end
      end
      lis_pkg::SEQ_WAIT: begin
        if (nxt_ot) begin
          nxt_st = lis_pkg::SEQ_OT;
        end else if (!allow) begin
          nxt_st = lis_pkg::SEQ_OFF;
        end else if (tmr_done) begin
          nxt_st = lis_pkg::SEQ_LASE;
        end
      end
      lis_pkg::SEQ_LASE: begin
        if (nxt_ot) begin
          nxt_st = lis_pkg::SEQ_OT;
        end else if (!allow) begin
          nxt_st = lis_pkg::SEQ_OFF;
        end
      end
      default: begin
        nxt_st = lis_pkg::SEQ_OT;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_comb begin
    // RF power in delay and lase states
    nxt_rf         = allow && !nxt_ot &&
                     ((nxt_st == lis_pkg::SEQ_WAIT) || (nxt_st == lis_pkg::SEQ_LASE));
    nxt_pwm_gate   = (nxt_st == lis_pkg::SEQ_LASE) && pwm_in;
    nxt_ready_oe_n = !(ready_cond && !nxt_ot);
    nxt_shut_oe_n  = !shut_stat;
    nxt_ilk_oe_n   = interlock_in;
    nxt_ot_oe_n    = !nxt_ot;
    nxt_lase_oe_n  = !nxt_pwm_gate;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff         <= lis_pkg::SEQ_OFF;
      ot_ff         <= 1'b0;
      rf_ff         <= 1'b0;
      pwm_gate_ff   <= 1'b0;
      ready_oe_n_ff <= 1'b1;
      shut_oe_n_ff  <= 1'b1;
      ilk_oe_n_ff   <= 1'b1;
      ot_oe_n_ff    <= 1'b1;
      lase_oe_n_ff  <= 1'b1;
    end else begin
      st_ff         <= nxt_st;
      ot_ff         <= nxt_ot;
      rf_ff         <= nxt_rf;
      pwm_gate_ff   <= nxt_pwm_gate;
      ready_oe_n_ff <= nxt_ready_oe_n;
      shut_oe_n_ff  <= nxt_shut_oe_n;
      ilk_oe_n_ff   <= nxt_ilk_oe_n;
      ot_oe_n_ff    <= nxt_ot_oe_n;
      lase_oe_n_ff  <= nxt_lase_oe_n;
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign setup  = psel && !penable;
  assign wr_acc = psel && penable && pready_ff && pwrite;

  always_comb begin
    nxt_ctrl    = ctrl_ff;
    nxt_pready  = setup;
    nxt_pslverr = setup && !is_mapped(paddr);
    nxt_prdata  = '0;
    if (wr_acc && (paddr == lis_pkg::OFS_CTRL)) begin
      nxt_ctrl = pwdata[lis_pkg::CTRL_SW_INHIBIT];
    end
    if (setup && !pwrite) begin
      if (paddr == lis_pkg::OFS_CTRL) begin
        nxt_prdata[lis_pkg::CTRL_SW_INHIBIT] = ctrl_ff;
      end else if (paddr == lis_pkg::OFS_STATUS) begin
        nxt_prdata[lis_pkg::ST_INTERLOCK] = interlock_in;
        nxt_prdata[lis_pkg::ST_SHUT_REQ]  = shutter_req_in;
        nxt_prdata[lis_pkg::ST_SHUT_SW]   = shutter_sw_open_in;
        nxt_prdata[lis_pkg::ST_INHIBIT]   = inhibit_req_in;
        nxt_prdata[lis_pkg::ST_READY]     = !ready_oe_n_ff;
        nxt_prdata[lis_pkg::ST_RF_POWER]  = rf_ff;
        nxt_prdata[lis_pkg::ST_LASE_EN]   = lase_en;
        nxt_prdata[lis_pkg::ST_OVERTEMP]  = ot_ff;
      end else if (paddr == lis_pkg::OFS_TIMER) begin
        nxt_prdata[lis_pkg::TMR_W-1:0] = tmr_cnt;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff    <= lis_pkg::CTRL_RST;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= '0;
    end else begin
      ctrl_ff    <= nxt_ctrl;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff  <= nxt_prdata;
    end
  end

  assign prdata              = prdata_ff;
  assign pready              = pready_ff;
  assign pslverr             = pslverr_ff;
  assign rf_power_en         = rf_ff;
  assign pwm_gate            = pwm_gate_ff;
  assign ready_oe_n          = ready_oe_n_ff;
  assign shutter_open_oe_n   = shut_oe_n_ff;
  assign interlock_open_oe_n = ilk_oe_n_ff;
  assign over_temp_oe_n      = ot_oe_n_ff;
  assign lase_active_oe_n    = lase_oe_n_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_powerup_ready: assert property (@(posedge pclk) disable iff (!presetn)
    (interlock_in && shutter_req_in && !inhibit_req_in && !ot_ff && !ctrl_ff && !over_temp_in)
    |=> !ready_oe_n_ff) else $error("Ready not asserted with conditions met.");

  a_ot_latched: assert property (@(posedge pclk) disable iff (!presetn)
    ot_ff |=> ot_ff && (st_ff == lis_pkg::SEQ_OT) && !rf_ff) else $error("Over-temperature cleared.");

  a_ilk_return: assert property (@(posedge pclk) disable iff (!presetn)
    (st_ff == lis_pkg::SEQ_OFF) && allow && !ot_ff && !over_temp_in
    |=> (st_ff == lis_pkg::SEQ_WAIT)) else $error("Delay not started on return.");

  a_inhibit_off: assert property (@(posedge pclk) disable iff (!presetn)
    inhibit_req_in |=> !rf_ff && !lase_en) else $error("RF on during inhibit.");

  a_lase_after_dly: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(lase_en) |-> $past(tmr_done) && $past(tmr_run)) else $error("Lasing before delay.");

  a_rf_needs_stat: assert property (@(posedge pclk) disable iff (!presetn)
    (ready_oe_n_ff || shut_oe_n_ff) |-> !rf_ff)
    else $error("RF on with ready or shutter inactive.");

  a_ready_follows: assert property (@(posedge pclk) disable iff (!presetn)
    lase_en |-> !ready_oe_n_ff) else $error("Ready open while lasing.");

  a_wait_full: assert property (@(posedge pclk) disable iff (!presetn)
    (st_ff == lis_pkg::SEQ_WAIT) && !tmr_done |=> !lase_en) else $error("Delay cut short.");

  a_rf_all_three: assert property (@(posedge pclk) disable iff (!presetn)
    rf_ff |-> $past(interlock_in) && $past(ready_cond) && $past(shut_stat))
    else $error("RF on without all conditions.");

  a_ilk_loss: assert property (@(posedge pclk) disable iff (!presetn)
    presetn && !interlock_in |=> !rf_ff && !ilk_oe_n_ff && ready_oe_n_ff && !lase_en)
    else $error("Interlock loss not handled.");

  a_ilk_switch: assert property (@(posedge pclk) disable iff (!presetn)
    presetn |=> (ilk_oe_n_ff == $past(interlock_in))) else $error("Interlock switch wrong.");

  a_shut_switch: assert property (@(posedge pclk) disable iff (!presetn)
    presetn |=> (shut_oe_n_ff == !($past(shutter_sw_open_in) && $past(shutter_req_in))))
    else $error("Shutter switch wrong.");

endmodule // lis_sequencer

`default_nettype wire

//--- rtl/lis_pkg.sv
// Package of constants and types for the laser enable interlock sequencer.

package lis_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 20_000_000;
  localparam int unsigned ENABLE_DLY_S = 5;
  localparam int unsigned ENABLE_DLY_CYC = CLK_HZ * ENABLE_DLY_S;
  localparam int unsigned TMR_W        = 27;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_TIMER  = 8'h08;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_SW_INHIBIT = 0;
  localparam logic       CTRL_RST         = 1'b0;

  localparam int unsigned ST_INTERLOCK = 0;
  localparam int unsigned ST_SHUT_REQ  = 1;
  localparam int unsigned ST_SHUT_SW   = 2;
  localparam int unsigned ST_INHIBIT   = 3;
  localparam int unsigned ST_READY     = 4;
  localparam int unsigned ST_RF_POWER  = 5;
  localparam int unsigned ST_LASE_EN   = 6;
  localparam int unsigned ST_OVERTEMP  = 7;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SEQ_OFF  = 2'b00,
    SEQ_WAIT = 2'b01,
    SEQ_LASE = 2'b10,
    SEQ_OT   = 2'b11
  } lis_state_t;

endpackage

//--- rtl/lis_delay_timer.sv
// Abortable enable delay counter.
`timescale 1ns/1ps
`default_nettype none

module lis_delay_timer #(
  parameter int unsigned LIMIT = lis_pkg::ENABLE_DLY_CYC
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     run,
  output logic [lis_pkg::TMR_W-1:0]     cnt,
  output logic                          done
);

  localparam logic [lis_pkg::TMR_W-1:0] LAST = lis_pkg::TMR_W'(LIMIT - 1);

  logic [lis_pkg::TMR_W-1:0] cnt_ff;
  logic [lis_pkg::TMR_W-1:0] nxt_cnt;
  logic                      done_ff;
  logic                      nxt_done;

  // ----------------------------------------------------------------
  // Next count
  // ----------------------------------------------------------------
  // abort and restart
  always_comb begin
    nxt_cnt = cnt_ff;
    if (!run) begin
      nxt_cnt = '0;
    end else if (cnt_ff != LAST) begin
      nxt_cnt = cnt_ff + 1'b1;
    end
    nxt_done = run && (nxt_cnt == LAST);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff  <= '0;
      done_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end

  assign cnt  = cnt_ff;
  assign done = done_ff;

  a_timer_abort_clr: assert property (@(posedge pclk) disable iff (!presetn)
    !run |=> (cnt_ff == '0) && !done_ff) else $error("Timer did not clear on abort.");

endmodule // lis_delay_timer

`default_nettype wire

//--- tb/lis_plc_model.sv
// Machine safety circuit model that drives the sequencer's safety inputs.
`timescale 1ns/1ps
`default_nettype none

module lis_plc_model #(
  parameter int unsigned STABLE_CYC = 30
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [5:0] cmd,
  output logic            interlock_in,
  output logic            shutter_req_in,
  output logic            shutter_sw_open_in,
  output logic            inhibit_req_in,
  output logic            over_temp_in,
  output logic            pwm_in
);
  logic [7:0] stable_cnt_ff;
  logic [7:0] nxt_stable_cnt;
  logic [5:0] out_ff;
  logic [5:0] nxt_out;

  always_comb begin
    nxt_stable_cnt = stable_cnt_ff;
    nxt_out = cmd;
    if (stable_cnt_ff < 8'(STABLE_CYC)) begin
      nxt_stable_cnt = stable_cnt_ff + 8'h01;
      nxt_out[3] = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stable_cnt_ff <= 8'h00;
      out_ff <= 6'h00;
    end else begin
      stable_cnt_ff <= nxt_stable_cnt;
      out_ff <= nxt_out;
    end
  end

  assign interlock_in = out_ff[0];
  assign shutter_req_in = out_ff[1];
  assign shutter_sw_open_in = out_ff[2];
  assign inhibit_req_in = out_ff[3];
  assign over_temp_in = out_ff[4];
  assign pwm_in = out_ff[5];
endmodule // lis_plc_model

`default_nettype wire

//--- tb/tb_top.sv
// Self-checking testbench for the laser enable interlock sequencer.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  localparam int unsigned DLY = 20;
  localparam logic [5:0] ALL = 6'h27;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        err;
  logic [5:0]  cmd;
  logic        interlock_in, shutter_req_in, shutter_sw_open_in, inhibit_req_in;
  logic        over_temp_in, pwm_in, rf_power_en, pwm_gate, ready_oe_n;
  logic        shutter_open_oe_n, interlock_open_oe_n, over_temp_oe_n, lase_active_oe_n;
  int          n_mismatch, n_tests;

  // ----------------------------------------------------------------
  // Instances
  // ----------------------------------------------------------------
  lis_sequencer #(.DLY_CYC(DLY)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .interlock_in(interlock_in),
    .shutter_req_in(shutter_req_in), .shutter_sw_open_in(shutter_sw_open_in),
    .inhibit_req_in(inhibit_req_in), .over_temp_in(over_temp_in), .pwm_in(pwm_in),
    .rf_power_en(rf_power_en), .pwm_gate(pwm_gate), .ready_oe_n(ready_oe_n),
    .shutter_open_oe_n(shutter_open_oe_n), .interlock_open_oe_n(interlock_open_oe_n),
    .over_temp_oe_n(over_temp_oe_n), .lase_active_oe_n(lase_active_oe_n));
  lis_plc_model #(.STABLE_CYC(30)) plc (.pclk(pclk), .presetn(presetn), .cmd(cmd),
    .interlock_in(interlock_in), .shutter_req_in(shutter_req_in),
    .shutter_sw_open_in(shutter_sw_open_in), .inhibit_req_in(inhibit_req_in),
    .over_temp_in(over_temp_in), .pwm_in(pwm_in));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic set_in(input logic [5:0] c);
    @(posedge pclk);
    cmd <= c;
    tick(2);
    @(negedge pclk);
  endtask

  task automatic wait_lase(input int lo);
    int n;
    n = 0;
    while (pwm_gate !== 1'b1 && n < 4 * DLY) begin
      @(negedge pclk);
      n++;
    end
    chk(32'(n >= lo && n <= DLY + 4), 32'h1);
    chk({ready_oe_n, lase_active_oe_n}, 2'b00);
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic do_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    tick(16);
    @(negedge pclk);
    chk({over_temp_oe_n, ready_oe_n, interlock_open_oe_n, rf_power_en}, 4'he);
    @(posedge pclk);
    presetn <= 1'b1;
    tick(2);
    @(negedge pclk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_power_up;
    do_reset();
    chk({rf_power_en, ready_oe_n, shutter_open_oe_n}, 3'b100);
    chk({interlock_open_oe_n, pwm_gate}, 2'b10);
    wait_lase(DLY - 2);
    set_in(ALL & ~6'h20);
    chk({pwm_gate, lase_active_oe_n, ready_oe_n, rf_power_en}, 4'b0101);
    set_in(ALL);
    chk({pwm_gate, lase_active_oe_n}, 2'b10);
    $display("test power_up done");
  endtask

  task automatic t_interlock;
    set_in(ALL & ~6'h01);
    chk({rf_power_en, ready_oe_n, interlock_open_oe_n, pwm_gate}, 4'b0100);
    set_in(ALL);
    chk({rf_power_en, ready_oe_n, interlock_open_oe_n}, 3'b101);
    tick(DLY / 2);
    apb(1'b0, lis_pkg::OFS_TIMER, 32'h0);
    chk(rd, 32'(DLY / 2 + 1));
    set_in(ALL & ~6'h01);
    set_in(ALL);
    wait_lase(DLY - 1);
    $display("test interlock done");
  endtask

  task automatic t_inhibit;
    logic bad;
    bad = 1'b0;
    set_in(ALL | 6'h08);
    repeat (3 * DLY) begin
      @(negedge pclk);
      bad = bad | (rf_power_en !== 1'b0) | (pwm_gate !== 1'b0);
    end
    chk(bad, 1'b0);
    set_in(ALL);
    chk(rf_power_en, 1'b1);
    wait_lase(DLY - 1);
    $display("test inhibit done");
  endtask

  task automatic t_shutter;
    set_in(ALL & ~6'h04);
    chk({shutter_open_oe_n, rf_power_en, pwm_gate}, 3'b100);
    set_in(ALL & ~6'h02);
    chk({shutter_open_oe_n, ready_oe_n, rf_power_en}, 3'b110);
    set_in(ALL);
    wait_lase(DLY - 1);
    $display("test shutter done");
  endtask

  task automatic t_regs;
    apb(1'b0, lis_pkg::OFS_STATUS, 32'h0);
    chk(rd, 32'h77);
    apb(1'b1, lis_pkg::OFS_STATUS, 32'hff);
    apb(1'b0, lis_pkg::OFS_STATUS, 32'h0);
    chk(err, 1'b0);
    chk(rd, 32'h77);
    apb(1'b0, 8'h10, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, lis_pkg::OFS_CTRL, 32'h1);
    tick(1);
    @(negedge pclk);
    chk({rf_power_en, pwm_gate}, 2'b00);
    apb(1'b0, lis_pkg::OFS_CTRL, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, lis_pkg::OFS_CTRL, 32'h0);
    wait_lase(DLY - 2);
    $display("test regs done");
  endtask

  task automatic t_overtemp;
    set_in(ALL | 6'h10);
    chk({over_temp_oe_n, rf_power_en, pwm_gate}, 3'b000);
    set_in(ALL);
    set_in(ALL | 6'h08);
    set_in(ALL);
    tick(2 * DLY);
    @(negedge pclk);
    chk({over_temp_oe_n, rf_power_en, pwm_gate}, 3'b000);
    do_reset();
    chk({over_temp_oe_n, rf_power_en}, 2'b11);
    wait_lase(DLY - 2);
    $display("test overtemp done");
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  initial begin
    tick(10000);
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    n_mismatch = 0;
    n_tests = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cmd = ALL;
    t_power_up();
    t_interlock();
    t_inhibit();
    t_shutter();
    t_regs();
    t_overtemp();
    report_and_stop();
  end
endmodule // tb_top

`default_nettype wire
